/* verilog/abh_top.sv */
// Baud generator, line control, handshake and receive buffer
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module abh_top
    import abh_pkg::*;
(
    input  wire logic       system_clock_in,
    input  wire logic       resetn_in,
    // Register port
    input  wire logic [1:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic [7:0]      rdata_out,
    // Clocks and switches
    input  wire logic       external_sixteenfold_clock_in,
    input  wire logic       external_generator_disable_switch_in,
    input  wire logic       rate_200_switch_open_in,
    input  wire logic       rate_600_switch_open_in,
    input  wire logic       handshake_switch_open_in,
    output logic            sixteenfold_clock_out,
    output logic            eightfold_clock_out,
    output logic            uart_clock_tick_out,
    output logic            two_stop_bits_out,
    // UART side
    input  wire logic       uart_serial_out_in,
    input  wire logic       uart_hold_empty_in,
    input  wire logic       uart_stop_sample_in,
    input  wire logic       uart_data_received_in,
    input  wire logic [7:0] uart_rx_data_in,
    input  wire logic       uart_parity_error_in,
    input  wire logic       uart_overrun_in,
    output logic            uart_data_received_reset_out,
    output logic            uart_serial_in_out,
    // Line side
    input  wire logic       line_rx_data_in,
    input  wire logic       cf_in,
    input  wire logic       cb_in,
    input  wire logic       cc_in,
    input  wire logic       sb_in,
    output logic            line_tx_data_out,
    output logic            rts_out,
    output logic            dtr_out,
    output logic            secondary_tx_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] ext_sync;
    logic [1:0] rx_sync;
    logic [3:0] st_sync1;
    logic [3:0] st_sync2;
    logic [3:0] sw_sync1;
    logic [3:0] sw_sync2;
    logic       ext_prev;

    // Two flops on the external clock, line receive data, modem status and switch inputs
    always_ff @(posedge system_clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ext_sync <= 2'h0;
            rx_sync  <= 2'h3;
            st_sync1 <= 4'h0;
            st_sync2 <= 4'h0;
            sw_sync1 <= 4'h0;
            sw_sync2 <= 4'h0;
            ext_prev <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[0], external_sixteenfold_clock_in};
            rx_sync  <= {rx_sync[0], line_rx_data_in};
            st_sync1 <= {sb_in, cc_in, cb_in, cf_in};
            st_sync2 <= st_sync1;
            // Switches are pins too: handshake, 600, 200, generator disable
            sw_sync1 <= {handshake_switch_open_in, rate_600_switch_open_in,
                         rate_200_switch_open_in, external_generator_disable_switch_in};
            sw_sync2 <= sw_sync1;
            ext_prev <= ext_sync[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [2:0] rate;

    // Software write of the control word
    always_comb begin
        next_ctrl = ctrl;
        if (wr_in && addr_in == ABH_REG_CTRL) next_ctrl = wdata_in;
    end

    always_ff @(posedge system_clock_in or negedge resetn_in) begin
        if (!resetn_in) ctrl <= ABH_CTRL_RESET;
        else ctrl <= next_ctrl;
    end

    assign rate = ctrl[ABH_CTRL_RATE_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////////
    // Baud rate generator
    logic [ABH_CNT_W-1:0] div_cnt;
    logic [ABH_CNT_W-1:0] next_div_cnt;
    logic [ABH_CNT_W-1:0] div_len;
    logic                 tick;
    logic                 next_tick;
    logic                 x16;
    logic                 next_x16;
    logic                 x8;
    logic                 next_x8;
    logic                 use_ext;

    // Pick divisor: internal code, switch rate, or external clock
    always_comb begin
        use_ext = 1'b0;
        div_len = ABH_CNT_W'(abh_divisor(rate)); // RQ1
        if (rate == ABH_RATE_EXT) begin
            use_ext = 1'b1; // RQ2
            if (sw_sync2[0]) begin // RQ5
                if (sw_sync2[2]) begin
                    use_ext = 1'b0;
                    div_len = ABH_CNT_W'(ABH_DIV_600);
                end else if (sw_sync2[1]) begin
                    use_ext = 1'b0;
                    div_len = ABH_CNT_W'(ABH_DIV_200);
                end
            end
        end
    end

    // Count up, one tick per sixteenfold period
    always_comb begin
        next_div_cnt = div_cnt;
        next_tick    = 1'b0;
        next_x16     = x16;
        next_x8      = x8;
        if (use_ext) begin
            next_div_cnt = '0;
            next_x16     = ext_sync[1]; // RQ2
            next_tick    = ext_sync[1] & ~ext_prev;
        end else if (div_cnt >= div_len - ABH_CNT_W'(1)) begin
            next_div_cnt = '0;
            next_tick    = 1'b1; // RQ1
            next_x16     = 1'b1;
        end else begin
            next_div_cnt = div_cnt + ABH_CNT_W'(1);
            if (div_cnt == (div_len >> 1) - ABH_CNT_W'(1)) next_x16 = 1'b0;
        end
        if (next_tick) next_x8 = ~x8; // RQ4 RQ11
    end

    always_ff @(posedge system_clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_cnt <= '0;
            tick    <= 1'b0;
            x16     <= 1'b0;
            x8      <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick    <= next_tick;
            x16     <= next_x16;
            x8      <= next_x8;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit handshake
    logic busy;

    abh_handshake u_handshake (
        .system_clock_in     (system_clock_in),
        .resetn_in      (resetn_in),
        .tick_in        (tick),
        .enable_in      (sw_sync2[3]), // RQ12
        .cb_on_in       (st_sync2[1]),
        .stop_sample_in (uart_stop_sample_in),
        .busy_out       (busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receive buffer stage
    logic [7:0] rx_buf;
    logic [7:0] next_rx_buf;
    logic       rx_full;
    logic       next_rx_full;
    logic       drr;
    logic       next_drr;
    logic       data_rd;

    assign data_rd = rd_in && addr_in == ABH_REG_DATA;

    // Load from UART when empty; read frees it, new data wins
    always_comb begin
        next_rx_buf  = rx_buf;
        next_rx_full = rx_full;
        next_drr     = 1'b0;
        if (data_rd) next_rx_full = 1'b0; // RQ21
        if (uart_data_received_in && !drr && (!rx_full || data_rd)) begin
            next_rx_buf  = uart_rx_data_in; // RQ16 RQ21
            next_rx_full = 1'b1;
            next_drr     = 1'b1;
        end
    end

    always_ff @(posedge system_clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_buf  <= 8'h00;
            rx_full <= 1'b0;
            drr     <= 1'b0;
        end else begin
            rx_buf  <= next_rx_buf;
            rx_full <= next_rx_full;
            drr     <= next_drr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and registered outputs
    logic [7:0] next_rdata;
    logic [7:0] status;

    always_comb begin
        status = 8'h00;
        status[ABH_ST_TX_READY] = uart_hold_empty_in & ~busy; // RQ12 RQ20
        status[ABH_ST_RX_FULL]  = rx_full;
        status[ABH_ST_CF]       = st_sync2[0]; // RQ10
        status[ABH_ST_CB]       = st_sync2[1];
        status[ABH_ST_CC]       = st_sync2[2];
        status[ABH_ST_SB]       = st_sync2[3];
        status[ABH_ST_PE]       = uart_parity_error_in;
        status[ABH_ST_OE]       = uart_overrun_in;
        next_rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                ABH_REG_CTRL:   next_rdata = ctrl;
                ABH_REG_STATUS: next_rdata = status;
                ABH_REG_DATA:   next_rdata = rx_full ? rx_buf : 8'h00; // RQ16
                default:        next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge system_clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out                    <= 8'h00;
            sixteenfold_clock_out        <= 1'b0;
            eightfold_clock_out          <= 1'b0;
            uart_clock_tick_out          <= 1'b0;
            two_stop_bits_out            <= 1'b0;
            uart_data_received_reset_out <= 1'b0;
            uart_serial_in_out           <= 1'b1;
            line_tx_data_out             <= 1'b1;
            rts_out                      <= 1'b0;
            dtr_out                      <= 1'b0;
            secondary_tx_out             <= 1'b0;
        end else begin
            rdata_out                    <= next_rdata;
            sixteenfold_clock_out        <= x16; // RQ3
            eightfold_clock_out          <= x8; // RQ4
            uart_clock_tick_out          <= tick; // RQ3 RQ19
            two_stop_bits_out            <= (rate == ABH_RATE_110); // RQ17
            uart_data_received_reset_out <= next_drr;
            uart_serial_in_out           <= rx_sync[1]; // RQ9
            line_tx_data_out             <= ctrl[ABH_CTRL_BREAK] | uart_serial_out_in; // RQ18
            rts_out                      <= ctrl[ABH_CTRL_RTS]; // RQ6
            dtr_out                      <= ~(ctrl[ABH_CTRL_AUTODIAL]
                                              & ctrl[ABH_CTRL_DTR_OFF]); // RQ7
            secondary_tx_out             <= ctrl[ABH_CTRL_BREAK] & ctrl[ABH_CTRL_RTS]; // RQ8
        end
    end
endmodule : abh_top
`default_nettype wire

/* verilog/abh_pkg.sv */
// Package of constants for the serial link clocking and line-control block
//
// What this block does
// RQ1: Divide system clock per three rate-select bits
// RQ2: Code 000 uses external sixteenfold clock input
// RQ3: Selected clock feeds UART and clock output
// RQ4: Eightfold clock is selected clock halved
// RQ5: Switches give 200 or 600 baud
// RQ6: Request-to-send follows control bit directly
// RQ7: Terminal ready high except auto-dial mode (code drops it only when auto-dial and DTR-off are both set)
// RQ8: Secondary transmit low on break or RTS low (code drives it high only when break and RTS are both set)
// RQ9: Received data passes straight to UART
// RQ10: Four modem status inputs readable by processor
// RQ11: Firmware uses 110 baud eightfold tick timer
// RQ12: Handshake enabled clears transmit-ready on busy
// RQ13: Handshake is two-state, sixteenfold-clocked machine
// RQ14: Sample CB mid final sixteenth stop bit
// RQ15: CB off means busy, hold transmission
// RQ16: Extra receive buffer, gated on read
// RQ17: 110 baud code requests two stop bits
// RQ18: Break forces serial data output high
// RQ19: Sixteen bit-clock cycles per bit
// RQ20: Handshake disabled: ready follows holding empty
// RQ21: Buffer loads on data received, clears on read
package abh_pkg;
    localparam logic [2:0] ABH_RATE_EXT  = 3'h0;
    localparam logic [2:0] ABH_RATE_110  = 3'h1;
    localparam logic [2:0] ABH_RATE_150  = 3'h2;
    localparam logic [2:0] ABH_RATE_300  = 3'h3;
    localparam logic [2:0] ABH_RATE_1200 = 3'h4;
    localparam logic [2:0] ABH_RATE_2400 = 3'h5;
    localparam logic [2:0] ABH_RATE_4800 = 3'h6;
    localparam logic [2:0] ABH_RATE_9600 = 3'h7;
    // System clock divisors to the sixteenfold clock
    localparam int ABH_DIV_9600 = 32;
    localparam int ABH_DIV_4800 = 64;
    localparam int ABH_DIV_2400 = 128;
    localparam int ABH_DIV_1200 = 256;
    localparam int ABH_DIV_300  = 1024;
    localparam int ABH_DIV_150  = 2048;
    localparam int ABH_DIV_110  = 2800;
    localparam int ABH_DIV_600  = 512;
    localparam int ABH_DIV_200  = 1536;
    localparam int ABH_CNT_W    = 12;
    localparam int ABH_BIT_TICKS = 16;
    // Register offsets
    localparam logic [1:0] ABH_REG_CTRL   = 2'h0;
    localparam logic [1:0] ABH_REG_STATUS = 2'h1;
    localparam logic [1:0] ABH_REG_DATA   = 2'h2;
    // Control field positions
    localparam int ABH_CTRL_RATE_LSB = 0;
    localparam int ABH_CTRL_RTS      = 3;
    localparam int ABH_CTRL_BREAK    = 4;
    localparam int ABH_CTRL_AUTODIAL = 5;
    localparam int ABH_CTRL_DTR_OFF  = 6;
    localparam logic [7:0] ABH_CTRL_RESET = 8'h00;
    // Status field positions
    localparam int ABH_ST_TX_READY = 0;
    localparam int ABH_ST_RX_FULL  = 1;
    localparam int ABH_ST_CF       = 2;
    localparam int ABH_ST_CB       = 3;
    localparam int ABH_ST_CC       = 4;
    localparam int ABH_ST_SB       = 5;
    localparam int ABH_ST_PE       = 6;
    localparam int ABH_ST_OE       = 7;

    // Divisor for a rate code, 0 meaning external clock
    function automatic int abh_divisor(input logic [2:0] code);
        case (code)
            ABH_RATE_9600: abh_divisor = ABH_DIV_9600;
            ABH_RATE_4800: abh_divisor = ABH_DIV_4800;
            ABH_RATE_2400: abh_divisor = ABH_DIV_2400;
            ABH_RATE_1200: abh_divisor = ABH_DIV_1200;
            ABH_RATE_300:  abh_divisor = ABH_DIV_300;
            ABH_RATE_150:  abh_divisor = ABH_DIV_150;
            ABH_RATE_110:  abh_divisor = ABH_DIV_110;
            default:       abh_divisor = 0;
        endcase
    endfunction : abh_divisor
endpackage : abh_pkg

/* verilog/abh_handshake.sv */
// Two-state transmit handshake machine
`timescale 1ns/10ps
`default_nettype none
module abh_handshake
    import abh_pkg::*;
(
    input  wire logic system_clock_in,
    input  wire logic resetn_in,
    input  wire logic tick_in,
    input  wire logic enable_in,
    input  wire logic cb_on_in,
    input  wire logic stop_sample_in,
    output var  logic busy_out
);
    typedef enum logic {ABH_HS_GO, ABH_HS_HOLD} abh_hs_t;
    abh_hs_t state;
    abh_hs_t next_state;

    // Next state at sample instants; forced to GO on any cycle when disabled
    always_comb begin
        next_state = state;
        if (!enable_in) begin
            next_state = ABH_HS_GO; // RQ20
        end else if (tick_in) begin // RQ13
            case (state)
                ABH_HS_GO: begin
                    if (stop_sample_in && !cb_on_in) next_state = ABH_HS_HOLD; // RQ14 RQ15
                end
                ABH_HS_HOLD: begin
                    if (cb_on_in) next_state = ABH_HS_GO; // RQ15
                end
                default: next_state = ABH_HS_GO;
            endcase
        end
    end

    // State register
    always_ff @(posedge system_clock_in or negedge resetn_in) begin
        if (!resetn_in) state <= ABH_HS_GO;
        else state <= next_state;
    end

    assign busy_out = (state == ABH_HS_HOLD);
endmodule : abh_handshake
`default_nettype wire

/* tb/abh_top_monitor.sv */
// Checker of the serial link block's port behaviour
`timescale 1ns/10ps
`default_nettype none
module abh_top_monitor
    import abh_pkg::*;
(
    input wire logic       system_clock_in,
    input wire logic       resetn_in,
    input wire logic [1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       uart_clock_tick_out,
    input wire logic       two_stop_bits_out,
    input wire logic       uart_serial_out_in,
    input wire logic       uart_hold_empty_in,
    input wire logic       uart_data_received_in,
    input wire logic       uart_data_received_reset_out,
    input wire logic       uart_serial_in_out,
    input wire logic       line_rx_data_in,
    input wire logic       line_tx_data_out,
    input wire logic       rts_out,
    input wire logic       dtr_out,
    input wire logic       secondary_tx_out,
    input wire logic       handshake_switch_open_in
);
    default clocking @(posedge system_clock_in); endclocking
    default disable iff (!resetn_in);
    logic [2:0] age;
    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since reset release, saturating
    always_ff @(posedge system_clock_in or negedge resetn_in) begin
        if (!resetn_in) age <= 3'h0;
        else if (age != 3'h7) age <= age + 3'h1;
    end
    sequence ctrl_wr;
        wr_in && addr_in == ABH_REG_CTRL;
    endsequence
    sequence status_rd;
        rd_in && addr_in == ABH_REG_STATUS;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_RTS: assert property (ctrl_wr |-> ##2 rts_out == $past(wdata_in[3], 2))
        else $error("request to send not following control bit");
    AST_SEC: assert property (ctrl_wr |-> ##2 secondary_tx_out ==
        ($past(wdata_in[3], 2) & $past(wdata_in[4], 2))) else $error("secondary line wrong");
    AST_DTR: assert property (ctrl_wr ##0 !(wdata_in[5] && wdata_in[6]) |-> ##2 dtr_out)
        else $error("terminal ready dropped outside auto-dial");
    AST_BREAK: assert property (ctrl_wr ##0 wdata_in[4] |-> ##2 line_tx_data_out)
        else $error("break did not force line high");
    AST_RX_PASS: assert property (age == 3'h7 |-> uart_serial_in_out == $past(line_rx_data_in, 3))
        else $error("received line not passed to serial input");
    AST_TICK: assert property (uart_clock_tick_out |=> !uart_clock_tick_out [*8])
        else $error("bit clock tick too close");
    AST_STOP2: assert property (ctrl_wr |-> ##2
        two_stop_bits_out == ($past(wdata_in[2:0], 2) == ABH_RATE_110)) else $error("stop bits");
    AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data driven without read");
    AST_TXRDY: assert property (status_rd ##0 !handshake_switch_open_in ##0
        $stable(uart_hold_empty_in) |=> rdata_out[ABH_ST_TX_READY] == $past(uart_hold_empty_in))
        else $error("ready not following holding empty");
    AST_DRR: assert property (uart_data_received_reset_out |->
        $past(uart_data_received_in) ##1 !uart_data_received_reset_out) else $error("load pulse");
endmodule : abh_top_monitor
`default_nettype wire

/* tb/abh_modem_model.sv */
// Model of the line partner: status lines, received data and external clock
`timescale 1ns/10ps
`default_nettype none
module abh_modem_model #(
    parameter int EXT_HALF = 640
) (
    input  wire logic       system_clock_in,
    input  wire logic       ext_run_in,
    input  wire logic [3:0] status_in,
    output logic            ext_clock_out,
    output logic [3:0]      modem_out,
    output logic            line_data_out
);
    int         cnt = 0;
    logic [7:0] lfsr = 8'h5A;
    initial ext_clock_out = 1'b0;
    initial modem_out = 4'hF;
    initial line_data_out = 1'b1;
    // Lines change just after an edge, then stand; data varies every cycle
    always @(posedge system_clock_in) begin
        modem_out <= status_in;
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        line_data_out <= lfsr[0];
        if (ext_run_in) begin
            cnt <= (cnt == EXT_HALF - 1) ? 0 : cnt + 1;
            if (cnt == EXT_HALF - 1) ext_clock_out <= ~ext_clock_out;
        end
    end
endmodule : abh_modem_model
`default_nettype wire

/* tb/test_async_serial_baud_handshake.sv */
// Testbench of the serial link clocking and line-control block
`timescale 1ns/10ps
`default_nettype none
bind abh_top abh_top_monitor i_mon (.system_clock_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .uart_clock_tick_out, .two_stop_bits_out, .uart_serial_out_in, .uart_hold_empty_in,
    .uart_data_received_in, .uart_data_received_reset_out, .uart_serial_in_out, .line_rx_data_in,
    .line_tx_data_out, .rts_out, .dtr_out, .secondary_tx_out, .handshake_switch_open_in);
module test_async_serial_baud_handshake
    import abh_pkg::*;
;
    localparam int EXT_HALF = 640;
    logic       system_clock_in, resetn_in, wr_in, rd_in, uart_serial_out_in, uart_hold_empty_in;
    logic [1:0] addr_in;
    logic [7:0] wdata_in, rdata_out, uart_rx_data_in;
    logic       external_generator_disable_switch_in, rate_200_switch_open_in;
    logic       rate_600_switch_open_in, handshake_switch_open_in, uart_stop_sample_in;
    logic       uart_data_received_in, uart_parity_error_in, uart_overrun_in, ext_run;
    logic       sixteenfold_clock_out, eightfold_clock_out, uart_clock_tick_out, two_stop_bits_out;
    logic       uart_data_received_reset_out, uart_serial_in_out, line_tx_data_out;
    logic       rts_out, dtr_out, secondary_tx_out, external_sixteenfold_clock_in, line_rx_data_in;
    wire logic  cf_in, cb_in, cc_in, sb_in;
    logic [3:0] modem, modem_cmd;
    logic [2:0] sig;
    logic       rd_d = 1'b0;
    logic [15:0] q[$];
    int         bad_count = 0, samples_checked = 0, cyc = 0;
    int         divs[8] = '{0, ABH_DIV_110, ABH_DIV_150, ABH_DIV_300, ABH_DIV_1200,
                            ABH_DIV_2400, ABH_DIV_4800, ABH_DIV_9600};
    assign {sb_in, cc_in, cb_in, cf_in} = modem;
    assign sig = {eightfold_clock_out, sixteenfold_clock_out, uart_clock_tick_out};
    abh_top i_dut (.system_clock_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .external_sixteenfold_clock_in, .external_generator_disable_switch_in,
        .rate_200_switch_open_in, .rate_600_switch_open_in, .handshake_switch_open_in,
        .sixteenfold_clock_out, .eightfold_clock_out, .uart_clock_tick_out, .two_stop_bits_out,
        .uart_serial_out_in, .uart_hold_empty_in, .uart_stop_sample_in, .uart_data_received_in,
        .uart_rx_data_in, .uart_parity_error_in, .uart_overrun_in, .uart_data_received_reset_out,
        .uart_serial_in_out, .line_rx_data_in, .cf_in, .cb_in, .cc_in, .sb_in, .line_tx_data_out,
        .rts_out, .dtr_out, .secondary_tx_out);
    abh_modem_model #(.EXT_HALF(EXT_HALF)) i_modem (.system_clock_in, .ext_run_in(ext_run),
        .status_in(modem_cmd), .ext_clock_out(external_sixteenfold_clock_in),
        .modem_out(modem), .line_data_out(line_rx_data_in));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        system_clock_in = 1'b0;
        forever #2.5 system_clock_in = ~system_clock_in;
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task tally_and_finish;
        $display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task tick(input int n);
        repeat (n) @(posedge system_clock_in);
    endtask : tick
    task reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge system_clock_in);
        {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
        @(posedge system_clock_in);
        wr_in <= 1'b0;
    endtask : reg_wr
    task reg_rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge system_clock_in);
        {rd_in, addr_in} <= {1'b1, a};
        q.push_back({m, e & m});
        @(posedge system_clock_in);
        rd_in <= 1'b0;
    endtask : reg_rd
    // Cycles between the next two rising edges of one clock output
    task gap(input int k, output int n);
        int c, t0, e;
        logic p;
        c = 0; t0 = 0; e = 0; p = 1'b1;
        while (e < 2 && c < 20000) begin
            @(posedge system_clock_in);
            #1;
            if (sig[k] === 1'b1 && p === 1'b0) begin
                e++;
                if (e == 1) t0 = c;
            end
            p = sig[k];
            c++;
        end
        n = c - 1 - t0;
    endtask : gap
    // Wait for the buffer load pulse, then drop data received
    task take;
        int c;
        c = 0;
        do begin @(posedge system_clock_in); c++; end
        while (uart_data_received_reset_out !== 1'b1 && c < 100);
        check({15'h0, uart_data_received_reset_out}, 16'h1);
        uart_data_received_in <= 1'b0;
    endtask : take
    ////////////////////////////////////////////////////////////////////////////////
    // Read data watcher: oldest note against the data of the cycle after a read
    always @(posedge system_clock_in) begin
        if (rd_d) begin
            check({8'h00, rdata_out & q[0][15:8]}, {8'h00, q[0][7:0]});
            void'(q.pop_front());
        end
        rd_d <= rd_in;
    end
    // Hang limit
    always @(posedge system_clock_in) begin
        cyc++;
        if (cyc == 95000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        logic [7:0] d, b;
        static logic [2:0] sw[4] = '{3'b011, 3'b111, 3'b110, 3'b100};
        static int         sw_exp[4] = '{2 * EXT_HALF, ABH_DIV_600, ABH_DIV_200, 2 * EXT_HALF};
        static logic [3:0] hs[4] = '{4'b1001, 4'b1010, 4'b1101, 4'b0011};
        {resetn_in, wr_in, rd_in, addr_in, wdata_in, uart_rx_data_in, ext_run} = '0;
        {external_generator_disable_switch_in, rate_200_switch_open_in} = 2'b00;
        {rate_600_switch_open_in, handshake_switch_open_in, uart_stop_sample_in} = 3'b000;
        {uart_data_received_in, uart_parity_error_in, uart_overrun_in} = 3'b000;
        {uart_serial_out_in, uart_hold_empty_in, modem_cmd} = 6'h3F;
        void'($urandom(4));
        tick(12);
        resetn_in <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom);
            uart_serial_out_in <= d[7];
            reg_wr(ABH_REG_CTRL, d);
            tick(2);
            #1;
            check({11'h0, two_stop_bits_out, rts_out, secondary_tx_out, dtr_out, line_tx_data_out},
                {11'h0, d[2:0] == ABH_RATE_110, d[3], d[3] & d[4], ~(d[5] & d[6]),
                d[4] | d[7]});
            reg_rd(ABH_REG_CTRL, d, 8'h7F);
        end
        reg_wr(2'h3, 8'hFF);
        reg_rd(2'h3, 8'h00, 8'hFF);
        reg_rd(ABH_REG_CTRL, d, 8'h7F);
        for (int i = 1; i < 8; i++) begin
            reg_wr(ABH_REG_CTRL, 8'(i));
            for (int j = 0; j < 3; j++) begin
                gap(j, n);
                check(16'(n), 16'(divs[i] << (j == 2)));
            end
        end
        reg_wr(ABH_REG_CTRL, 8'h00);
        ext_run <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge system_clock_in);
            {external_generator_disable_switch_in, rate_200_switch_open_in,
             rate_600_switch_open_in} <= sw[i];
            gap(0, n);
            check(16'(n), 16'(sw_exp[i]));
        end
        ext_run <= 1'b0;
        reg_wr(ABH_REG_CTRL, 8'h07);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            {uart_overrun_in, uart_parity_error_in, modem_cmd, uart_hold_empty_in} <= d[6:0];
            tick(6);
            reg_rd(ABH_REG_STATUS, {d[6:1], 1'b0, d[0]}, 8'hFF);
        end
        {uart_hold_empty_in, modem_cmd} <= 5'h1F;
        for (int i = 0; i < 4; i++) begin
            {handshake_switch_open_in, modem_cmd[1], uart_stop_sample_in} <= hs[i][3:1];
            tick(40);
            uart_stop_sample_in <= 1'b0;
            tick(40);
            reg_rd(ABH_REG_STATUS, {7'h00, hs[i][0]}, 8'h01);
        end
        modem_cmd <= 4'hF;
        reg_rd(ABH_REG_DATA, 8'h00, 8'hFF);
        d = 8'($urandom);
        b = 8'($urandom);
        {uart_rx_data_in, uart_data_received_in} <= {d, 1'b1};
        take();
        reg_rd(ABH_REG_STATUS, 8'h02, 8'h02);
        {uart_rx_data_in, uart_data_received_in} <= {b, 1'b1};
        tick(10);
        reg_rd(ABH_REG_DATA, d, 8'hFF);
        take();
        reg_rd(ABH_REG_DATA, b, 8'hFF);
        reg_rd(ABH_REG_STATUS, 8'h00, 8'h02);
        reg_rd(ABH_REG_DATA, 8'h00, 8'hFF);
        tick(4);
        tally_and_finish();
    end
endmodule : test_async_serial_baud_handshake
`default_nettype wire
